// ### rtl/twms_slave.sv
// Purpose: two-wire slave giving byte access to a memory array and to a
//          register bank through one user-side access port
// Assumes: link logic runs on link_clk_i, fast enough to oversample the
//          serial clock; user answers a read one clock_i cycle after
//          acc_valid_o
// Notes:   the array and register contents live outside this block
`timescale 1ns/1ps

module twms_slave (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [1:0] dev_sel_i,
   output logic acc_valid_o,
   output twms_pkg::twms_req_t acc_o,
   input wire logic [7:0] rdata_i
);

   // ---------------- link domain ----------------
   logic lrst_s1_reg, lrst_reg;
   logic scl_s1_reg, scl_s2_reg, scl_d_reg;
   logic sda_s1_reg, sda_s2_reg, sda_d_reg;
   logic [1:0] sel_s1_reg, sel_s2_reg;
   logic ack_s1_reg, ack_s2_reg;
   logic req_tgl_reg;
   twms_pkg::twms_req_t req_reg;
   twms_pkg::twms_state_t st_reg;
   twms_pkg::twms_role_t role_reg;
   logic [7:0] sh_reg;
   logic [2:0] cnt_reg;
   logic is_reg_reg, rd_reg_sel, macked_reg, oe_reg;
   logic [6:0] ahi_reg;
   logic [twms_pkg::MEM_ADDR_W-1:0] mem_addr_reg;
   logic [twms_pkg::REG_ADDR_W-1:0] reg_addr_reg;
   logic scl_rise, scl_fall, start_ev, stop_ev, busy;
   logic [7:0] sh_next;
   logic [twms_pkg::MEM_ADDR_W-1:0] cur_addr;
   logic [twms_pkg::MEM_ADDR_W-1:0] mem_inc;
   logic [twms_pkg::REG_ADDR_W-1:0] reg_inc;

   // ---------------- system domain ----------------
   logic rq_s1_reg, rq_s2_reg, rq_s3_reg;
   logic pend_reg, ack_tgl_reg, acc_valid_reg;
   twms_pkg::twms_req_t acc_reg;
   logic [7:0] rd_data_reg;

   // reset is carried into the link domain through two flops
   always_ff @(posedge link_clk_i) begin
      lrst_s1_reg <= sys_rst_i;
      lrst_reg <= lrst_s1_reg;
   end

   always_ff @(posedge link_clk_i) begin
      scl_s1_reg <= scl_i;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      sel_s1_reg <= dev_sel_i;
      sel_s2_reg <= sel_s1_reg;
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
   end

   assign scl_rise = scl_s2_reg & ~scl_d_reg;
   assign scl_fall = ~scl_s2_reg & scl_d_reg;
   assign start_ev = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
   assign stop_ev = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
   assign busy = req_tgl_reg ^ ack_s2_reg;
   assign sh_next = {sh_reg[6:0], sda_s2_reg};
   assign cur_addr = is_reg_reg ?
      {{(twms_pkg::MEM_ADDR_W-twms_pkg::REG_ADDR_W){1'b0}}, reg_addr_reg} :
      mem_addr_reg;
   assign mem_inc = mem_addr_reg + 15'h0001;
   // register addresses stop at 18h, so the latch wraps there
   assign reg_inc = (reg_addr_reg == twms_pkg::REG_ADDR_TOP) ?
      twms_pkg::REG_ADDR_RST : reg_addr_reg + 5'h01;

   always_ff @(posedge link_clk_i) begin
      if (lrst_reg) begin
         st_reg <= twms_pkg::TWMS_IDLE;
         role_reg <= twms_pkg::TWMS_R_SLV;
         sh_reg <= 8'h00;
         cnt_reg <= 3'h0;
         is_reg_reg <= 1'b0;
         rd_reg_sel <= 1'b0;
         macked_reg <= 1'b0;
         oe_reg <= 1'b0;
         ahi_reg <= 7'h00;
         mem_addr_reg <= twms_pkg::MEM_ADDR_RST;
         reg_addr_reg <= twms_pkg::REG_ADDR_RST;
         req_tgl_reg <= 1'b0;
         req_reg <= '0;
      end else if (start_ev) begin
         // a partial byte never launched a commit, so nothing is written
         st_reg <= twms_pkg::TWMS_RX;
         role_reg <= twms_pkg::TWMS_R_SLV;
         cnt_reg <= 3'h0;
         oe_reg <= 1'b0;
      end else if (stop_ev) begin
         st_reg <= twms_pkg::TWMS_IDLE;
         oe_reg <= 1'b0;
      end else begin
         case (st_reg)
            twms_pkg::TWMS_RX: begin
               if (scl_rise) begin
                  sh_reg <= sh_next;
                  cnt_reg <= cnt_reg + 3'h1;
                  if (cnt_reg == twms_pkg::BIT_LAST) begin
                     st_reg <= twms_pkg::TWMS_ACKW;
                     case (role_reg)
                        twms_pkg::TWMS_R_SLV: begin
                           if (sh_next[twms_pkg::SA_SEL_MSB:
                                 twms_pkg::SA_SEL_LSB] != sel_s2_reg ||
                                (sh_next[twms_pkg::SA_ID_MSB:
                                 twms_pkg::SA_ID_LSB] != twms_pkg::ID_MEM &&
                                 sh_next[twms_pkg::SA_ID_MSB:
                                 twms_pkg::SA_ID_LSB] != twms_pkg::ID_REG))
                              st_reg <= twms_pkg::TWMS_IDLE;
                           is_reg_reg <= sh_next[twms_pkg::SA_ID_MSB:
                              twms_pkg::SA_ID_LSB] == twms_pkg::ID_REG;
                           if (sh_next[twms_pkg::SA_RW]) begin
                              role_reg <= twms_pkg::TWMS_R_RD;
                              rd_reg_sel <= 1'b1;
                           end else if (sh_next[twms_pkg::SA_ID_MSB:
                                 twms_pkg::SA_ID_LSB] == twms_pkg::ID_REG) begin
                              role_reg <= twms_pkg::TWMS_R_ALO;
                           end else begin
                              role_reg <= twms_pkg::TWMS_R_AHI;
                           end
                        end
                        twms_pkg::TWMS_R_AHI: begin
                           ahi_reg <= sh_next[6:0];
                           role_reg <= twms_pkg::TWMS_R_ALO;
                        end
                        twms_pkg::TWMS_R_ALO: begin
                           role_reg <= twms_pkg::TWMS_R_DATA;
                           if (is_reg_reg) begin
                              if (sh_next > twms_pkg::REG_ADDR_MAX)
                                 st_reg <= twms_pkg::TWMS_IDLE;
                              else
                                 reg_addr_reg <= sh_next[4:0];
                           end else begin
                              mem_addr_reg <= {ahi_reg, sh_next};
                           end
                        end
                        default: begin
                           // commit the byte, then advance the address
                           req_reg <= '{is_reg: is_reg_reg, wr: 1'b1,
                              addr: cur_addr, wdata: sh_next};
                           req_tgl_reg <= ~req_tgl_reg;
                           if (is_reg_reg)
                              reg_addr_reg <= reg_inc;
                           else
                              mem_addr_reg <= mem_inc;
                        end
                     endcase
                  end
               end
            end
            twms_pkg::TWMS_ACKW: begin
               // the acknowledge waits for the commit or fetch to finish
               if (!busy && !scl_s2_reg) begin
                  oe_reg <= 1'b1;
                  st_reg <= twms_pkg::TWMS_ACKD;
               end
               if (rd_reg_sel) begin
                  rd_reg_sel <= 1'b0;
                  req_reg <= '{is_reg: is_reg_reg, wr: 1'b0,
                     addr: cur_addr, wdata: 8'h00};
                  req_tgl_reg <= ~req_tgl_reg;
               end
            end
            twms_pkg::TWMS_ACKD, twms_pkg::TWMS_MACK: begin
               if (scl_rise)
                  macked_reg <= ~sda_s2_reg;
               if (scl_fall) begin
                  cnt_reg <= 3'h0;
                  if (role_reg == twms_pkg::TWMS_R_RD &&
                      (st_reg == twms_pkg::TWMS_ACKD || macked_reg)) begin
                     sh_reg <= rd_data_reg;
                     oe_reg <= ~rd_data_reg[7];
                     st_reg <= twms_pkg::TWMS_TX;
                  end else if (st_reg == twms_pkg::TWMS_MACK) begin
                     oe_reg <= 1'b0;
                     st_reg <= twms_pkg::TWMS_IDLE;
                  end else begin
                     oe_reg <= 1'b0;
                     st_reg <= twms_pkg::TWMS_RX;
                  end
               end
            end
            twms_pkg::TWMS_TX: begin
               if (scl_fall) begin
                  cnt_reg <= cnt_reg + 3'h1;
                  sh_reg <= {sh_reg[6:0], 1'b0};
                  oe_reg <= ~sh_reg[6];
                  if (cnt_reg == twms_pkg::BIT_LAST) begin
                     // advance before the ack and prefetch the next byte
                     oe_reg <= 1'b0;
                     macked_reg <= 1'b0;
                     st_reg <= twms_pkg::TWMS_MACK;
                     req_tgl_reg <= ~req_tgl_reg;
                     if (is_reg_reg) begin
                        reg_addr_reg <= reg_inc;
                        req_reg <= '{is_reg: 1'b1, wr: 1'b0,
                           addr: {10'h000, reg_inc}, wdata: 8'h00};
                     end else begin
                        mem_addr_reg <= mem_inc;
                        req_reg <= '{is_reg: 1'b0, wr: 1'b0,
                           addr: mem_inc, wdata: 8'h00};
                     end
                  end
               end
            end
            default: begin
               oe_reg <= 1'b0;
            end
         endcase
      end
   end

   // open drain: the line is only ever pulled low
   always_ff @(posedge link_clk_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= oe_reg & ~lrst_reg;
   end

   // ---------------- system domain side ----------------
   always_ff @(posedge clock_i) begin
      rq_s1_reg <= req_tgl_reg;
      rq_s2_reg <= rq_s1_reg;
      rq_s3_reg <= rq_s2_reg;
   end

   // request words are held stable by the link until the answer toggle
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         acc_valid_reg <= 1'b0;
         acc_reg <= '0;
         pend_reg <= 1'b0;
         ack_tgl_reg <= 1'b0;
         rd_data_reg <= 8'h00;
      end else begin
         acc_valid_reg <= rq_s2_reg ^ rq_s3_reg;
         pend_reg <= acc_valid_reg;
         if (rq_s2_reg ^ rq_s3_reg)
            acc_reg <= req_reg;
         if (pend_reg) begin
            if (!acc_reg.wr)
               rd_data_reg <= rdata_i;
            ack_tgl_reg <= ~ack_tgl_reg;
         end
      end
   end

   assign acc_valid_o = acc_valid_reg;
   assign acc_o = acc_reg;

endmodule // twms_slave

// ### rtl/twms_pkg.sv
// Purpose: shared constants and carrier types for the two-wire memory and
//          register slave
// Assumes: 256Kb memory density, register bank at addresses 00h..18h
// Notes:   access requests cross from the link domain to the system domain
package twms_pkg;

   localparam int MEM_ADDR_W = 15;
   localparam int REG_ADDR_W = 5;

   localparam logic [3:0] ID_MEM = 4'hA;
   localparam logic [3:0] ID_REG = 4'hD;
   localparam logic [7:0] REG_ADDR_MAX = 8'h18;

   // field positions inside the slave address byte
   localparam int SA_ID_MSB = 7;
   localparam int SA_ID_LSB = 4;
   localparam int SA_SEL_MSB = 2;
   localparam int SA_SEL_LSB = 1;
   localparam int SA_RW = 0;

   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [MEM_ADDR_W-1:0] MEM_ADDR_RST = 15'h0000;
   localparam logic [REG_ADDR_W-1:0] REG_ADDR_RST = 5'h00;
   localparam logic [REG_ADDR_W-1:0] REG_ADDR_TOP = 5'h18;

   // bus phases, gray coded along idle -> rx -> ack -> tx -> master ack
   typedef enum logic [2:0] {
      TWMS_IDLE = 3'h0,
      TWMS_RX   = 3'h1,
      TWMS_ACKW = 3'h3,
      TWMS_ACKD = 3'h2,
      TWMS_TX   = 3'h6,
      TWMS_MACK = 3'h7
   } twms_state_t;

   // meaning of the byte currently on the bus
   typedef enum logic [2:0] {
      TWMS_R_SLV  = 3'h0,
      TWMS_R_AHI  = 3'h1,
      TWMS_R_ALO  = 3'h3,
      TWMS_R_DATA = 3'h2,
      TWMS_R_RD   = 3'h6
   } twms_role_t;

   typedef struct packed {
      logic is_reg;
      logic wr;
      logic [MEM_ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } twms_req_t;

endpackage

// ### testbench/twms_slave_checker.sv
// Purpose: concurrent checks on the two-wire slave ports
// Assumes: sys_rst_i resets both the system and the link domain
// Notes: bound to twms_slave from the bench top file
`timescale 1ns/1ps
module twms_slave_checker (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic acc_valid_o,
   input wire twms_pkg::twms_req_t acc_o
);
   sequence s_start;
      scl_i && $past(scl_i) && $fell(sda_i);
   endsequence
   sequence s_scl_high;
      scl_i && $past(scl_i);
   endsequence
   property p_start_release;
      @(posedge link_clk_i) disable iff (sys_rst_i)
      s_start |=> !sda_oe_o [*8];
   endproperty
   property p_oe_scl_low;
      @(posedge link_clk_i) disable iff (sys_rst_i)
      $rose(sda_oe_o) |-> !scl_i;
   endproperty
   property p_oe_hold_high;
      @(posedge link_clk_i) disable iff (sys_rst_i)
      s_scl_high |-> $stable(sda_oe_o);
   endproperty
   property p_drive_low;
      @(posedge link_clk_i) disable iff (sys_rst_i)
      sda_oe_o |-> sda_o == 1'b0;
   endproperty
   property p_pulse_gap;
      @(posedge clock_i) disable iff (sys_rst_i)
      acc_valid_o |=> !acc_valid_o [*8];
   endproperty
   property p_acc_hold;
      @(posedge clock_i) disable iff (sys_rst_i)
      $changed(acc_o) |-> acc_valid_o;
   endproperty
   property p_reg_range;
      @(posedge clock_i) disable iff (sys_rst_i)
      acc_valid_o && acc_o.is_reg |-> acc_o.addr <= 15'h0018;
   endproperty
   property p_rst_clear;
      @(posedge clock_i) disable iff (sys_rst_i)
      $fell(sys_rst_i) |-> acc_o == '0 && !acc_valid_o;
   endproperty
   a_start_release: assert property (p_start_release)
      else $error("sda driven right after a start");
   a_oe_scl_low: assert property (p_oe_scl_low)
      else $error("sda drive began while scl high");
   a_oe_hold_high: assert property (p_oe_hold_high)
      else $error("sda drive changed while scl high");
   a_drive_low: assert property (p_drive_low)
      else $error("sda driven high");
   a_pulse_gap: assert property (p_pulse_gap)
      else $error("access pulses too close");
   a_acc_hold: assert property (p_acc_hold)
      else $error("request changed without a pulse");
   a_reg_range: assert property (p_reg_range)
      else $error("register request beyond the bank");
   a_rst_clear: assert property (p_rst_clear)
      else $error("request not clear after reset");
endmodule // twms_slave_checker

// ### testbench/twms_master_model.sv
// Purpose: two-wire bus master for the slave bench
// Assumes: sda has a pull-up; wire level comes back on sda_line_i
// Notes: bit cell is 20 clock_i cycles so scl low outlasts ack latency
`timescale 1ns/1ps
module twms_master_model (
   input wire logic clock_i,
   input wire logic sda_line_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // also serves as repeated start from scl low
   task automatic start();
      w(3);
      sda_o <= 1'b1;
      w(3);
      scl_o <= 1'b1;
      w(5);
      sda_o <= 1'b0;
      w(5);
      scl_o <= 1'b0;
   endtask
   task automatic stop();
      w(3);
      sda_o <= 1'b0;
      w(3);
      scl_o <= 1'b1;
      w(5);
      sda_o <= 1'b1;
      w(5);
   endtask
   task automatic bitx(input logic b, output logic r);
      w(5);
      sda_o <= b;
      w(5);
      scl_o <= 1'b1;
      w(5);
      r = sda_line_i;
      w(5);
      scl_o <= 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(!mack, r);
   endtask
endmodule // twms_master_model

// ### testbench/tb.sv
// Purpose: self-checking bench for the two-wire slave
// Assumes: user side answers every request with a value made from its address
// Notes: select pins fixed at 2h, bench drives them once
`timescale 1ns/1ps
module tb;
   logic clock_i, link_clk_i, sys_rst_i, scl, m_sda, sda_o, sda_oe_o;
   logic acc_valid_o, ack;
   wire sda_w;
   logic [1:0] dev_sel_i;
   logic [7:0] rdata_i, d0, d1;
   twms_pkg::twms_req_t acc_o;
   twms_pkg::twms_req_t wq[$];
   int mismatches, n_compared, cycles;
   assign sda_w = m_sda & ~sda_oe_o;
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #1.7;
      forever #3 link_clk_i = ~link_clk_i;
   end
   twms_slave twms_slave_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .dev_sel_i(dev_sel_i),
      .acc_valid_o(acc_valid_o), .acc_o(acc_o), .rdata_i(rdata_i));
   twms_master_model twms_master_model_inst (.clock_i(clock_i),
      .sda_line_i(sda_w), .scl_o(scl), .sda_o(m_sda));
   function automatic logic [7:0] fv(input twms_pkg::twms_req_t q);
      return q.addr[7:0] ^ (q.is_reg ? 8'hC3 : 8'h5A);
   endfunction
   task automatic conclude();
      $display("mismatches %0d compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // user side answers in the cycle after the pulse
   always @(posedge clock_i) begin
      cycles++;
      if (acc_valid_o === 1'b1) begin
         rdata_i <= fv(acc_o);
         if (acc_o.wr === 1'b1) wq.push_back(acc_o);
      end
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic st();
      twms_master_model_inst.start();
   endtask
   task automatic sp();
      twms_master_model_inst.stop();
   endtask
   task automatic wb(input logic [7:0] b, input logic e);
      twms_master_model_inst.wbyte(b, ack);
      check(ack, e);
   endtask
   task automatic rb(input logic mack, output logic [7:0] d);
      twms_master_model_inst.rbyte(mack, d);
   endtask
   task automatic t_first_read();
      st();
      wb(8'hA5, 1'b1);
      rb(1'b0, d0);
      sp();
      check(d0, 16'h005A);
   endtask
   task automatic t_write_wrap();
      wq.delete();
      st();
      wb(8'hA4, 1'b1);
      wb(8'hFF, 1'b1);
      wb(8'hFF, 1'b1);
      wb(8'h11, 1'b1);
      wb(8'h22, 1'b1);
      sp();
      check(wq.size(), 16'h0002);
      check(wq[0].addr, 16'h7FFF);
      check(wq[1].addr, 16'h0000);
      check({wq[0].is_reg, wq[1].is_reg}, 16'h0000);
      check({wq[0].wdata, wq[1].wdata}, 16'h1122);
   endtask
   task automatic t_abort_sel();
      logic r;
      wq.delete();
      st();
      wb(8'hA4, 1'b1);
      wb(8'h00, 1'b1);
      wb(8'h40, 1'b1);
      repeat (4) twms_master_model_inst.bitx(1'b0, r);
      sp();
      check(wq.size(), 16'h0000);
      st();
      wb(8'hA4, 1'b1);
      wb(8'h00, 1'b1);
      wb(8'h30, 1'b1);
      st();
      wb(8'hA5, 1'b1);
      rb(1'b1, d0);
      rb(1'b0, d1);
      sp();
      check({d0, d1}, 16'h6A6B);
   endtask
   task automatic t_reg();
      wq.delete();
      st();
      wb(8'hD4, 1'b1);
      wb(8'h03, 1'b1);
      wb(8'h77, 1'b1);
      sp();
      check({wq[0].is_reg, wq[0].addr}, 16'h8003);
      check(wq[0].wdata, 16'h0077);
      st();
      wb(8'hD5, 1'b1);
      rb(1'b0, d0);
      sp();
      check(d0, 16'h00C7);
      st();
      wb(8'hA5, 1'b1);
      rb(1'b0, d1);
      sp();
      check(d1, 16'h0068);
   endtask
   task automatic t_refuse();
      wq.delete();
      st();
      wb(8'hD4, 1'b1);
      wb(8'h19, 1'b0);
      sp();
      st();
      wb(8'hA2, 1'b0);
      sp();
      st();
      wb(8'h54, 1'b0);
      sp();
      check(wq.size(), 16'h0000);
   endtask
   initial begin
      sys_rst_i = 1'b1;
      dev_sel_i = 2'h2;
      rdata_i = 8'h00;
      mismatches = 0;
      n_compared = 0;
      cycles = 0;
      repeat (5) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      t_first_read();
      t_write_wrap();
      t_abort_sel();
      t_reg();
      t_refuse();
      conclude();
   end
endmodule // tb
bind twms_slave twms_slave_checker twms_slave_checker_inst (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .acc_valid_o(acc_valid_o), .acc_o(acc_o));
